/* File: pkg/wwcm_pkg.sv */
package wwcm_pkg;

	// System clock and instruction cycle divider
	localparam int CLK_PERIOD_NS = 10;
	localparam logic [7:0] TC_DIV_DEF = 8'h0a;

	// Register byte offsets on the bus
	localparam logic [7:0] ADR_SERVICE = 8'h00;
	localparam logic [7:0] ADR_CONFIG = 8'h04;
	localparam logic [7:0] ADR_STATUS = 8'h08;
	localparam logic [7:0] ADR_IDLE_TMR = 8'h0c;
	localparam logic [7:0] ADR_ELAPSED = 8'h10;

	// Service register layout
	localparam int SVC_CM_BIT = 0;
	localparam int SVC_KEY_LSB = 1;
	localparam int SVC_SEL_LSB = 6;
	localparam logic [4:0] KEY_VALUE = 5'h0c;
	localparam logic [1:0] SEL_RST = 2'h3;
	localparam logic CM_EN_RST = 1'b1;

	// Configuration register layout
	localparam int CFG_RC_BIT = 0;
	localparam int CFG_CLOCK_START_DELAY_SEL_BIT = 1;
	localparam int CFG_WDOFF_BIT = 2;
	localparam logic [2:0] CFG_RST = 3'h0;

	// Status register layout
	localparam int STS_PEND_BIT = 0;
	localparam int STS_FIRST_BIT = 1;
	localparam int STS_FAULT_BIT = 2;
	localparam int STS_CMERR_BIT = 3;
	localparam int STS_WDERR_BIT = 4;
	localparam int STS_PIN_BIT = 5;

	// Timing in instruction cycles
	localparam logic [16:0] LOWER_LIMIT_TC = 17'h00100;
	localparam logic [16:0] UPPER_BASE_TC = 17'h02000;
	localparam logic [5:0] FAULT_HOLD_TC = 6'h18;
	localparam logic [11:0] IDLE_WRAP_TC = 12'hfff;

	// Oscillator silence that counts as a clock failure
	localparam int CM_TIMEOUT_NS = 1000000;
	localparam int CM_TIMEOUT_CYC = CM_TIMEOUT_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {FLT_IDLE, FLT_DRIVE, FLT_HOLD, FLT_RELEASE} wwcm_flt_t;

endpackage : wwcm_pkg

/* File: hdl/wwcm_top.sv */
`timescale 1ns/1ps
module wwcm_top
	import wwcm_pkg::*;
#(
	parameter logic [7:0] TC_DIV = TC_DIV_DEF,
	parameter int CM_TIMEOUT = CM_TIMEOUT_CYC
)
(
	input wire logic clock, // System clock, 100 MHz
	input wire logic reset, // Synchronous reset, active high
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic halt_mode, // Core is in HALT
	input wire logic idle_mode, // Core is in IDLE
	input wire logic oscillator_input_pin, // Oscillator pin, asynchronous
	input wire logic fault_out_n_in, // Level read back from fault pin
	output logic fault_out_n_out, // Fault pin drive value
	output logic fault_out_n_oe, // Fault pin driven low when high
	output logic idle_tick_pending // Idle timer tick flag
);

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [7:0] tc_cnt;
		logic instruction_cycle;
		logic first_done;
		logic [1:0] win_sel;
		logic cm_en;
		logic [2:0] cfg;
		logic [16:0] elapsed;
		wwcm_flt_t flt;
		logic [5:0] hold;
		logic [23:0] cm_cnt;
		logic cm_err;
		logic wd_seen;
		logic [15:0] idle_tmr;
		logic idle_pend;
		logic halt_d;
		logic idle_d;
		logic [2:0] pin_sync;
		logic pin_lvl;
		logic [2:0] cki_sync;
		logic cki_lvl;
	} wwcm_state_t;

	localparam logic [23:0] CM_LIMIT = 24'(CM_TIMEOUT);

	wwcm_state_t q;
	wwcm_state_t d;
	logic bus_req;
	logic bus_wr;
	logic svc_wr;
	logic svc_take;
	logic svc_good;
	logic svc_bad;
	logic key_ok;
	logic fields_ok;
	logic too_early;
	logic wd_off;
	logic run;
	logic late;
	logic wd_err;
	logic trig;
	logic cki_edge;
	logic [16:0] limit;
	logic [31:0] rdata;

	always_comb
	begin
		d = q;
		bus_req = wb_cyc_i && wb_stb_i;
		// Writes land on the edge where the master samples ack
		bus_wr = bus_req && wb_we_i && q.ack;
		svc_wr = bus_wr && (wb_adr_i == ADR_SERVICE) && wb_sel_i[0];
		wd_off = q.cfg[CFG_WDOFF_BIT];
		limit = UPPER_BASE_TC << q.win_sel;
		key_ok = wb_dat_i[SVC_SEL_LSB-1:SVC_KEY_LSB] == KEY_VALUE;
		fields_ok = key_ok && (wb_dat_i[7:SVC_SEL_LSB] == q.win_sel)
			&& (wb_dat_i[SVC_CM_BIT] == q.cm_en);
		too_early = q.elapsed < LOWER_LIMIT_TC;
		run = !wd_off && (q.flt == FLT_IDLE) && !halt_mode && !idle_mode;
		late = run && q.instruction_cycle && (q.elapsed == limit - 17'h00001);
		svc_take = svc_wr && (q.flt == FLT_IDLE);
		// The initial window has no lower limit
		svc_good = svc_take
			&& (q.first_done ? (fields_ok && !too_early) : key_ok);
		svc_bad = svc_take && !svc_good;
		wd_err = svc_bad || (late && !svc_good);
		trig = !wd_off && (wd_err || q.cm_err);

		// Instruction cycle enable
		d.instruction_cycle = 1'b0;
		if (q.tc_cnt == TC_DIV - 8'h01)
		begin
			d.tc_cnt = 8'h00;
			d.instruction_cycle = 1'b1;
		end
		else
		begin
			d.tc_cnt = q.tc_cnt + 8'h01;
		end

		// Pin synchronisers; a level is taken once stages two and three agree
		d.pin_sync = {q.pin_sync[1:0], fault_out_n_in};
		d.pin_lvl = (q.pin_sync[1] == q.pin_sync[2]) ? q.pin_sync[2] : q.pin_lvl;
		d.cki_sync = {q.cki_sync[1:0], oscillator_input_pin};
		cki_edge = (q.cki_sync[1] == q.cki_sync[2]) && (q.cki_sync[2] != q.cki_lvl);

		// Clock monitor: silence on the oscillator pin for longer than the
		// limit is a failure; it ignores HALT and IDLE on purpose
		if (cki_edge)
		begin
			d.cki_lvl = q.cki_sync[2];
			d.cm_cnt = 24'h000000;
		end
		else if (q.cm_cnt < CM_LIMIT)
		begin
			d.cm_cnt = q.cm_cnt + 24'h000001;
		end
		d.cm_err = q.cm_en && (q.cm_cnt >= CM_LIMIT) && !cki_edge;

		// Window counter
		if (run && q.instruction_cycle && (q.elapsed != limit))
		begin
			d.elapsed = q.elapsed + 17'h00001;
		end
		d.halt_d = halt_mode;
		d.idle_d = idle_mode;
		if (q.halt_d && !halt_mode && !(q.cfg[CFG_RC_BIT] && !q.cfg[CFG_CLOCK_START_DELAY_SEL_BIT]))
		begin
			// RC without start delay resumes where it stopped
			d.elapsed = 17'h00000;
		end
		if (q.idle_d && !idle_mode)
		begin
			d.elapsed = 17'h00000;
		end
		if (svc_good)
		begin
			d.elapsed = 17'h00000;
			if (!q.first_done)
			begin
				d.first_done = 1'b1;
				d.win_sel = wb_dat_i[7:SVC_SEL_LSB];
				d.cm_en = wb_dat_i[SVC_CM_BIT];
			end
		end

		// Fault pin sequencing
		case (q.flt)
			FLT_IDLE:
			begin
				if (trig)
				begin
					d.flt = FLT_DRIVE;
				end
			end
			FLT_DRIVE:
			begin
				if (!q.pin_lvl)
				begin
					d.flt = FLT_HOLD;
					d.hold = 6'h00;
				end
			end
			FLT_HOLD:
			begin
				// A persisting clock error keeps restarting the hold
				if (q.cm_err)
				begin
					d.hold = 6'h00;
				end
				else if (q.instruction_cycle)
				begin
					if (q.hold == FAULT_HOLD_TC - 6'h01)
					begin
						d.flt = FLT_RELEASE;
					end
					else
					begin
						d.hold = q.hold + 6'h01;
					end
				end
			end
			FLT_RELEASE:
			begin
				if (q.pin_lvl)
				begin
					d.flt = FLT_IDLE;
					d.elapsed = 17'h00000;
				end
			end
			default:
			begin
				d.flt = FLT_IDLE;
			end
		endcase
		if (wd_off)
		begin
			d.flt = FLT_IDLE;
		end

		// Idle timer runs free; write loads it
		if (q.instruction_cycle)
		begin
			d.idle_tmr = q.idle_tmr + 16'h0001;
		end
		if (bus_wr && (wb_adr_i == ADR_IDLE_TMR))
		begin
			if (wb_sel_i[0])
			begin
				d.idle_tmr[7:0] = wb_dat_i[7:0];
			end
			if (wb_sel_i[1])
			begin
				d.idle_tmr[15:8] = wb_dat_i[15:8];
			end
		end
		if (bus_wr && (wb_adr_i == ADR_CONFIG) && wb_sel_i[0])
		begin
			d.cfg = wb_dat_i[2:0];
		end
		// Sticky flags: write one clears, a new event in the same cycle wins
		if (bus_wr && (wb_adr_i == ADR_STATUS) && wb_sel_i[0])
		begin
			if (wb_dat_i[STS_PEND_BIT])
			begin
				d.idle_pend = 1'b0;
			end
			if (wb_dat_i[STS_WDERR_BIT])
			begin
				d.wd_seen = 1'b0;
			end
		end
		if (q.instruction_cycle && (q.idle_tmr[11:0] == IDLE_WRAP_TC))
		begin
			d.idle_pend = 1'b1;
		end
		if (!wd_off && wd_err && (q.flt == FLT_IDLE))
		begin
			d.wd_seen = 1'b1;
		end

		// Read mux
		rdata = 32'h00000000;
		if (wb_adr_i == ADR_SERVICE)
		begin
			rdata[7:SVC_SEL_LSB] = q.win_sel;
			rdata[SVC_CM_BIT] = q.cm_en;
		end
		else if (wb_adr_i == ADR_CONFIG)
		begin
			rdata[2:0] = q.cfg;
		end
		else if (wb_adr_i == ADR_STATUS)
		begin
			rdata[STS_PEND_BIT] = q.idle_pend;
			rdata[STS_FIRST_BIT] = q.first_done;
			rdata[STS_FAULT_BIT] = q.flt != FLT_IDLE;
			rdata[STS_CMERR_BIT] = q.cm_err;
			rdata[STS_WDERR_BIT] = q.wd_seen;
			rdata[STS_PIN_BIT] = q.pin_lvl;
		end
		else if (wb_adr_i == ADR_IDLE_TMR)
		begin
			rdata[15:0] = q.idle_tmr;
		end
		else if (wb_adr_i == ADR_ELAPSED)
		begin
			rdata[16:0] = q.elapsed;
		end
		d.ack = bus_req && !q.ack;
		if (bus_req && !q.ack)
		begin
			d.dat = rdata;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			q <= '0;
			q.win_sel <= SEL_RST;
			q.cm_en <= CM_EN_RST;
			q.cfg <= CFG_RST;
			q.pin_lvl <= 1'b1;
			q.pin_sync <= 3'h7;
			q.idle_tmr <= q.idle_tmr;
		end
		else
		begin
			q <= d;
		end
	end

	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.dat;
	// Open-drain style: only ever pulls low, the pull-up is outside
	assign fault_out_n_out = 1'b0;
	assign fault_out_n_oe = !q.cfg[CFG_WDOFF_BIT]
		&& ((q.flt == FLT_DRIVE) || (q.flt == FLT_HOLD));
	assign idle_tick_pending = q.idle_pend;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	a_key_hidden: assert property (
		wb_ack_o && !wb_we_i && (wb_adr_i == ADR_SERVICE) |-> wb_dat_o[5:1] == 5'h00)
		else $error("service key visible on read");
	a_reset_defaults: assert property (
		$past(reset) |-> (q.win_sel == 2'h3) && q.cm_en && !q.first_done
			&& (q.flt == FLT_IDLE))
		else $error("wrong state after reset");
	a_late_fault: assert property (
		run && q.instruction_cycle && (q.elapsed == limit - 17'h00001) && !svc_wr
		|=> q.flt == FLT_DRIVE)
		else $error("late service not flagged");
	a_window_bound: assert property (
		(q.flt == FLT_IDLE) && !wd_off |-> q.elapsed < (17'h02000 << q.win_sel))
		else $error("window passed its upper limit");
	a_bad_first_key: assert property (
		svc_take && !q.first_done && (wb_dat_i[5:1] != 5'h0c) && !wd_off
		|=> (q.flt == FLT_DRIVE) && !q.first_done)
		else $error("bad first key accepted");
	a_field_mismatch: assert property (
		svc_take && q.first_done && !wd_off
			&& (wb_dat_i[7:0] != {q.win_sel, 5'h0c, q.cm_en})
		|=> q.flt == FLT_DRIVE)
		else $error("mismatched service accepted");
	a_first_service: assert property (
		svc_take && !q.first_done && (wb_dat_i[5:1] == 5'h0c)
		|=> q.first_done && (q.elapsed == 17'h00000)
			&& (q.win_sel == $past(wb_dat_i[7:6])))
		else $error("first service did not configure");
	a_busy_ignored: assert property (
		svc_wr && (q.flt != FLT_IDLE) |=> $stable(q.first_done) && $stable(q.win_sel))
		else $error("service taken during fault");
	a_early_error: assert property (
		svc_take && q.first_done && (q.elapsed < 17'h00100) && !wd_off
		|=> q.flt == FLT_DRIVE)
		else $error("early service not flagged");
	a_hold_release: assert property (
		$fell(fault_out_n_oe) && !wd_off |-> $past(q.hold) == 6'h17)
		else $error("fault released at wrong time");
	a_cm_hold: assert property (
		q.cm_err && (q.flt == FLT_HOLD) && !wd_off
		|=> (q.flt == FLT_HOLD) && (q.hold == 6'h00))
		else $error("fault released during clock error");
	a_halt_freeze: assert property (
		halt_mode && $past(halt_mode) && ($past(q.flt) == FLT_IDLE)
			&& (q.flt == FLT_IDLE) && !$past(svc_wr)
		|-> $stable(q.elapsed))
		else $error("window counted in HALT");
	a_idle_tick: assert property (
		q.instruction_cycle && (q.idle_tmr[11:0] == 12'hfff) |=> q.idle_pend)
		else $error("idle tick flag missed");
	a_wdog_off: assert property (
		wd_off |-> !fault_out_n_oe)
		else $error("fault pin driven with watchdog off");

	c_valid_service: cover property (svc_good && q.first_done);
	c_late_fault: cover property (late && !svc_good);
	c_cm_fault: cover property (q.cm_err && (q.flt == FLT_HOLD));
	c_release: cover property ((q.flt == FLT_RELEASE) && q.pin_lvl);

endmodule : wwcm_top

/* File: tb/wwcm_pin_partner.sv */
`timescale 1ns/1ps
module wwcm_pin_partner
(
	input wire logic osc_run, // Oscillator running
	input wire logic drive_out, // Value the device puts on the pin
	input wire logic drive_oe, // Device pulls the pin
	output logic pin_level, // Resolved pin level
	output logic osc_pin // Oscillator waveform
);
	// The weak pull-up wins whenever the device lets go
	assign pin_level = drive_oe ? drive_out : 1'b1;
	// Phase unrelated to the system clock; stands still when stopped
	initial
	begin
		osc_pin = 1'b0;
		forever #37 osc_pin = osc_run ? ~osc_pin : osc_pin;
	end
endmodule : wwcm_pin_partner

/* File: tb/wwcm_tb_top.sv */
`timescale 1ns/1ps
module wwcm_tb_top
	import wwcm_pkg::*;
;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic idle = 1'b0;
	logic halt = 1'b0;
	logic osc_run = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic ack, oe, drv, pin, osc, tick;
	logic [31:0] bad [4] = '{32'h59, 32'h99, 32'h18, 32'h1b};
	int fails = 0;
	int check_count = 0;
	int r, h;

	wwcm_top #(.TC_DIV(8'h02), .CM_TIMEOUT(200)) wwcm_top_i (
		.clock(clock), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.halt_mode(halt), .idle_mode(idle), .oscillator_input_pin(osc),
		.fault_out_n_in(pin), .fault_out_n_out(drv), .fault_out_n_oe(oe),
		.idle_tick_pending(tick));

	wwcm_pin_partner wwcm_pin_partner_i (.osc_run(osc_run), .drive_out(drv),
		.drive_oe(oe), .pin_level(pin), .osc_pin(osc));

	initial forever #5 clock = ~clock;

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	// Entered just after a rising edge; holds the request until ack is seen
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		// Read data is taken at the very edge that samples ack high
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk("ack_seen", 32'h1, n < 20);
		@(posedge clock);
	endtask : bus

	// Cycles until the pin is pulled, then cycles it stays pulled
	task automatic flt(input int lim, output int rise, output int hold);
		rise = 0;
		hold = 0;
		while (oe !== 1'b1 && rise < lim)
		begin
			@(negedge clock);
			rise++;
		end
		while (oe === 1'b1 && hold < 300)
		begin
			@(negedge clock);
			hold++;
		end
		@(posedge clock);
	endtask : flt

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	initial
	begin
		repeat (90000) @(posedge clock);
		fails++;
		end_of_test;
	end

	initial
	begin
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		bus(1'b1, ADR_IDLE_TMR, 32'h0ff0);
		repeat (40) @(posedge clock);
		chk("tick_set", 32'h1, {31'h0, tick});
		bus(1'b1, ADR_STATUS, 32'h1);
		chk("tick_clr", 32'h0, {31'h0, tick});
		reset <= 1'b1;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		bus(1'b0, ADR_IDLE_TMR, 32'h0);
		chk("timer_kept", 32'h1, q[15:0] >= 16'h1000 && q[15:0] < 16'h1040);
		bus(1'b0, ADR_SERVICE, 32'h0);
		chk("svc_reset", 32'hc1, q);
		bus(1'b1, ADR_SERVICE, 32'h19);
		flt(100, r, h);
		chk("first_ok", 32'h64, r);
		bus(1'b0, ADR_SERVICE, 32'h0);
		chk("svc_read", 32'h01, q);
		bus(1'b0, ADR_STATUS, 32'h0);
		chk("status", 32'h22, q);
		bus(1'b1, ADR_SERVICE, 32'h19);
		flt(20, r, h);
		chk("early", 32'h1, r < 5);
		chk("hold", 32'h1, h >= 32 && h <= 72);
		repeat (600) @(posedge clock);
		bus(1'b1, ADR_SERVICE, 32'h19);
		flt(20000, r, h);
		chk("late", 32'h1, r >= 16376 && r <= 16390);
		foreach (bad[i])
		begin
			repeat (600) @(posedge clock);
			bus(1'b1, ADR_SERVICE, bad[i]);
			flt(20, r, h);
			chk("mismatch", 32'h1, r < 5);
		end
		repeat (600) @(posedge clock);
		// HALT stops the oscillator; the monitor must still see it
		osc_run <= 1'b0;
		halt <= 1'b1;
		flt(400, r, h);
		chk("cm_err", 32'h1, r >= 180 && r <= 230);
		chk("cm_stays", 32'h12c, h);
		bus(1'b0, ADR_STATUS, 32'h0);
		chk("cm_status", 32'h1e, q & 32'h3e);
		osc_run <= 1'b1;
		halt <= 1'b0;
		flt(10, r, h);
		chk("cm_release", 32'h1, h >= 32 && h <= 80);
		repeat (600) @(posedge clock);
		bus(1'b1, ADR_SERVICE, 32'h19);
		// Leave the lower limit behind so only the automatic service makes the next write early
		repeat (600) @(posedge clock);
		idle <= 1'b1;
		flt(17000, r, h);
		chk("idle_stop", 32'h4268, r);
		idle <= 1'b0;
		@(posedge clock);
		bus(1'b1, ADR_SERVICE, 32'h19);
		flt(20, r, h);
		chk("idle_auto", 32'h1, r < 5);
		repeat (600) @(posedge clock);
		bus(1'b1, ADR_SERVICE, 32'h19);
		repeat (600) @(posedge clock);
		halt <= 1'b1;
		bus(1'b0, ADR_ELAPSED, 32'h0);
		h = q;
		repeat (20) @(posedge clock);
		bus(1'b0, ADR_ELAPSED, 32'h0);
		chk("halt_stop", h, q);
		halt <= 1'b0;
		@(posedge clock);
		bus(1'b0, ADR_ELAPSED, 32'h0);
		chk("halt_reload", 32'h1, q < 32'h4);
		repeat (600) @(posedge clock);
		bus(1'b1, ADR_CONFIG, 32'h1);
		halt <= 1'b1;
		bus(1'b0, ADR_ELAPSED, 32'h0);
		h = q;
		repeat (20) @(posedge clock);
		halt <= 1'b0;
		@(posedge clock);
		bus(1'b0, ADR_ELAPSED, 32'h0);
		chk("halt_resume", 32'h1, q >= h && q < h + 8);
		bus(1'b1, ADR_CONFIG, 32'h4);
		bus(1'b0, ADR_CONFIG, 32'h0);
		chk("cfg", 32'h4, q);
		bus(1'b1, ADR_SERVICE, 32'h19);
		bus(1'b1, ADR_SERVICE, 32'h19);
		flt(100, r, h);
		chk("wd_off", 32'h64, r);
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, q);
		end_of_test;
	end
endmodule : wwcm_tb_top
